// File: core_stack_mem.sv
// behavioural stack ram standing on the core side of the stack port
`timescale 1ns/1ps
module core_stack_mem (
    // stack port
    input wire logic        clk_sys,
    input wire logic        stack_mem_wr,
    input wire logic [15:0] stack_mem_addr,
    input wire logic [15:0] stack_push_data_lo,
    input wire logic [15:0] stack_push_data_hi,
    // read back of the addressed word pair
    output logic     [15:0] rd_lo,
    output logic     [15:0] rd_hi
);
    // word indexed: bit zero of a stack address carries nothing
    logic [15:0] mem_lo [4096];
    logic [15:0] mem_hi [4096];
    always @(posedge clk_sys) begin
        if (stack_mem_wr) begin
            mem_lo[stack_mem_addr[12:1]] <= stack_push_data_lo;
            mem_hi[stack_mem_addr[12:1]] <= stack_push_data_hi;
        end
    end
    assign rd_lo = mem_lo[stack_mem_addr[12:1]];
    assign rd_hi = mem_hi[stack_mem_addr[12:1]];
endmodule // core_stack_mem

// File: ram_segment_guard.sv
// ram segment guard: one protected data segment tied to one code segment
`timescale 1ns/1ps
`include "stack_guard_regs.svh"

module ram_segment_guard (
    // data access
    input  wire logic        acc_valid,
    input  wire logic [15:0] acc_addr,
    // segment window
    input  wire logic        seg_enable,
    input  wire logic [15:0] seg_start,
    input  wire logic [15:0] seg_end,
    // executing code
    input  wire logic        code_in_owner,
    // result
    output logic             acc_violation
);
    logic in_seg;

    always_comb begin
        in_seg        = (acc_addr >= seg_start) && (acc_addr <= seg_end);
        acc_violation = acc_valid && seg_enable && in_seg && !code_in_owner;
    end
endmodule // ram_segment_guard

// File: stack_guard_assertions.sv
// checker for the stack limit and ram guard block
`timescale 1ns/1ps
module stack_guard_assertions (
    // watched ports
    input wire logic clk_sys, srst, sp_call_push, sp_exc_push, sp_wr, limit_wr,
    input wire stack_guard_pkg::sp_op_type sp_op,
    input wire logic [22:0] pc_value,
    input wire logic [7:0] status_low_byte,
    input wire logic [15:0] ea_addr, limit_wr_data, stack_pointer_working_reg, stack_upper_bound_reg,
    input wire logic [15:0] stack_mem_addr, stack_push_data_hi,
    input wire logic stack_mem_wr, stack_mem_rd, trap_overflow, trap_underflow
);
    logic [15:0] sp;
    logic [15:0] lim;
    logic [6:0] pc_top;
    logic pu;
    logic po;
    assign sp = stack_pointer_working_reg;
    assign lim = stack_upper_bound_reg;
    assign pc_top = pc_value[22:16];
    assign pu = sp_op == stack_guard_pkg::SP_OP_PUSH && !sp_wr;
    assign po = sp_op == stack_guard_pkg::SP_OP_POP && !sp_wr;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    chk_push_write: assert property (
        pu && sp >= 16'h0800 && sp <= lim |=> stack_mem_wr && stack_mem_addr == $past(sp) && sp == $past(sp) + 16'h0002)
        else $error("push did not write and advance");
    chk_push_over: assert property (
        pu && sp > lim |=> trap_overflow && !stack_mem_wr && $stable(sp))
        else $error("push past limit not trapped");
    chk_pop_read: assert property (
        po && sp >= 16'h0802 && sp - 16'h0002 <= lim |=> stack_mem_rd && stack_mem_addr == sp)
        else $error("pop did not step back then read");
    chk_pop_under: assert property (
        po && sp < 16'h0802 |=> trap_underflow && !stack_mem_rd)
        else $error("pop below floor not trapped");
    chk_ea_over: assert property (
        sp_op == stack_guard_pkg::SP_OP_EA && !sp_wr && ea_addr > lim && ea_addr >= 16'h0800 |=> trap_overflow)
        else $error("address above limit not trapped");
    chk_limit_low: assert property (
        limit_wr |=> lim == ($past(limit_wr_data) & 16'hFFFE))
        else $error("limit bit zero not cleared");
    chk_call_high: assert property (
        pu && sp_call_push && !sp_exc_push |=> stack_mem_wr |-> stack_push_data_hi == {9'h000, $past(pc_top)})
        else $error("call push upper part not zero");
    chk_exc_high: assert property (
        pu && sp_exc_push |=> stack_mem_wr |-> stack_push_data_hi == {$past(status_low_byte), 1'h0, $past(pc_top)})
        else $error("exception push lacks status byte");
endmodule // stack_guard_assertions
bind stack_limit_and_ram_guard stack_guard_assertions stack_guard_assertions_inst (.*);

// File: stack_guard_pkg.sv
// shared types for the stack limit and ram guard block
package stack_guard_pkg;
    typedef enum logic [1:0] {
        SP_OP_NONE,
        SP_OP_PUSH,
        SP_OP_POP,
        SP_OP_EA
    } sp_op_type;
endpackage

// File: stack_guard_regs.svh
// constants for the stack limit and ram guard block
`ifndef STACK_GUARD_REGS_SVH
`define STACK_GUARD_REGS_SVH

`define SG_WORD_STEP      16'h0002
`define SG_UNDERFLOW_BASE 16'h0800
`define SG_SP_RESET       16'h0800
`define SG_ALIGN_MASK     16'hFFFE
`define SG_PC_HI_ZERO     8'h00

`endif

// File: stack_limit_and_ram_guard.sv
// stack pointer bookkeeping, limit checking and ram segment protection
//
// Functional notes
// - pointer holds first free word address; stack grows upward.
// - push writes at pointer then adds a word; pop decrements first, then reads.
// - call pushes program counter with upper part zero filled.
// - exception push places status low byte in upper part of pushed word.
// - stack limit register has no reset value; undefined until written.
// - limit bit zero always reads zero; writes to it ignored.
// - every pointer-based effective address compared with the limit.
// - push at pointer equal to limit succeeds; next push traps.
// - underflow trap when pointer address falls below fixed lower bound.
// - boot guarded ram reachable only from boot flash code when enabled.
// - secure guarded ram reachable only from secure flash code when enabled.
`timescale 1ns/1ps
`include "stack_guard_regs.svh"

module stack_limit_and_ram_guard (
    // clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       srst,
    // stack operation request from the core
    input  wire stack_guard_pkg::sp_op_type sp_op,
    input  wire logic                       sp_call_push,
    input  wire logic                       sp_exc_push,
    input  wire logic [22:0]                pc_value,
    input  wire logic [7:0]                 status_low_byte,
    input  wire logic [15:0]                ea_addr,
    // pointer and limit writes
    input  wire logic                       sp_wr,
    input  wire logic [15:0]                sp_wr_data,
    input  wire logic                       limit_wr,
    input  wire logic [15:0]                limit_wr_data,
    // ram segment protection
    input  wire logic                       data_acc_valid,
    input  wire logic [15:0]                data_acc_addr,
    input  wire logic                       boot_ram_prot_en,
    input  wire logic [15:0]                boot_ram_start,
    input  wire logic [15:0]                boot_ram_end,
    input  wire logic                       code_in_boot_flash,
    input  wire logic                       secure_ram_prot_en,
    input  wire logic [15:0]                secure_ram_start,
    input  wire logic [15:0]                secure_ram_end,
    input  wire logic                       code_in_secure_flash,
    // stack state and memory access
    output logic [15:0]                     stack_pointer_working_reg,
    output logic [15:0]                     stack_upper_bound_reg,
    output logic [15:0]                     stack_mem_addr,
    output logic [15:0]                     stack_push_data_lo,
    output logic [15:0]                     stack_push_data_hi,
    output logic                            stack_mem_wr,
    output logic                            stack_mem_rd,
    // traps
    output logic                            trap_overflow,
    output logic                            trap_underflow,
    output logic                            boot_ram_violation,
    output logic                            secure_ram_violation
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] sp_ff,    nxt_sp;
    logic [15:0] limit_ff, nxt_limit;
    logic [15:0] addr_ff,  nxt_addr;
    logic [15:0] lo_ff,    nxt_lo;
    logic [15:0] hi_ff,    nxt_hi;
    logic        wr_ff,    nxt_wr;
    logic        rd_ff,    nxt_rd;
    logic        ovf_ff,   nxt_ovf;
    logic        udf_ff,   nxt_udf;
    logic [15:0] check_addr;

    // address that the current pointer operation touches
    function automatic logic [15:0] op_addr(input stack_guard_pkg::sp_op_type op,
                                            input logic [15:0] sp, input logic [15:0] ea);
        case (op)
            stack_guard_pkg::SP_OP_PUSH: op_addr = sp;
            stack_guard_pkg::SP_OP_POP:  op_addr = sp - `SG_WORD_STEP;
            stack_guard_pkg::SP_OP_EA:   op_addr = ea;
            default:                     op_addr = sp;
        endcase
    endfunction

    always_comb begin
        nxt_sp     = sp_ff;
        nxt_limit  = limit_ff;
        nxt_addr   = addr_ff;
        nxt_lo     = lo_ff;
        nxt_hi     = hi_ff;
        nxt_wr     = 1'b0;
        nxt_rd     = 1'b0;
        nxt_ovf    = 1'b0;
        nxt_udf    = 1'b0;
        check_addr = op_addr(sp_op, sp_ff, ea_addr);
        if (limit_wr) begin
            nxt_limit = limit_wr_data & `SG_ALIGN_MASK;
        end
        if (sp_wr) begin
            nxt_sp = sp_wr_data & `SG_ALIGN_MASK;
        end else begin
            case (sp_op)
                stack_guard_pkg::SP_OP_PUSH: begin
                    nxt_addr = sp_ff;
                    nxt_wr   = 1'b1;
                    nxt_sp   = sp_ff + `SG_WORD_STEP;
                    nxt_lo   = pc_value[15:0];
                    if (sp_exc_push) begin
                        nxt_hi = {status_low_byte, 1'b0, pc_value[22:16]};
                    end else if (sp_call_push) begin
                        nxt_hi = {`SG_PC_HI_ZERO, 1'b0, pc_value[22:16]};
                    end else begin
                        nxt_hi = 16'h0000;
                    end
                end
                stack_guard_pkg::SP_OP_POP: begin
                    nxt_sp   = sp_ff - `SG_WORD_STEP;
                    nxt_addr = sp_ff - `SG_WORD_STEP;
                    nxt_rd   = 1'b1;
                end
                stack_guard_pkg::SP_OP_EA: begin
                    nxt_addr = ea_addr;
                    nxt_rd   = 1'b1;
                end
                default: begin
                    nxt_addr = addr_ff;
                end
            endcase
            if (sp_op != stack_guard_pkg::SP_OP_NONE) begin
                // a push at sp equal to limit still fits; only beyond it traps
                // a pop from a pointer below one word would wrap to the top; call it underflow
                nxt_udf = (check_addr < `SG_UNDERFLOW_BASE) ||
                          ((sp_op == stack_guard_pkg::SP_OP_POP) && (sp_ff < `SG_WORD_STEP));
                nxt_ovf = (check_addr > limit_ff) && !nxt_udf;
            end
            // a trapped access is not carried out
            if (nxt_ovf || nxt_udf) begin
                nxt_wr = 1'b0;
                nxt_rd = 1'b0;
                nxt_sp = sp_ff;
            end
        end
    end

    // limit has no reset on purpose: software must load it
    always_ff @(posedge clk_sys) begin
        limit_ff <= nxt_limit;
        addr_ff  <= nxt_addr;
        lo_ff    <= nxt_lo;
        hi_ff    <= nxt_hi;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sp_ff  <= `SG_SP_RESET;
            wr_ff  <= 1'b0;
            rd_ff  <= 1'b0;
            ovf_ff <= 1'b0;
            udf_ff <= 1'b0;
        end else begin
            sp_ff  <= nxt_sp;
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            ovf_ff <= nxt_ovf;
            udf_ff <= nxt_udf;
        end
    end

    // ------------------------------------------------------------
    // ram segment protection
    // ------------------------------------------------------------
    ram_segment_guard u_boot_guard (
        .acc_valid     (data_acc_valid),
        .acc_addr      (data_acc_addr),
        .seg_enable    (boot_ram_prot_en),
        .seg_start     (boot_ram_start),
        .seg_end       (boot_ram_end),
        .code_in_owner (code_in_boot_flash),
        .acc_violation (boot_ram_violation)
    );

    ram_segment_guard u_secure_guard (
        .acc_valid     (data_acc_valid),
        .acc_addr      (data_acc_addr),
        .seg_enable    (secure_ram_prot_en),
        .seg_start     (secure_ram_start),
        .seg_end       (secure_ram_end),
        .code_in_owner (code_in_secure_flash),
        .acc_violation (secure_ram_violation)
    );

    assign stack_pointer_working_reg = sp_ff;
    assign stack_upper_bound_reg     = limit_ff;
    assign stack_mem_addr            = addr_ff;
    assign stack_push_data_lo        = lo_ff;
    assign stack_push_data_hi        = hi_ff;
    assign stack_mem_wr              = wr_ff;
    assign stack_mem_rd              = rd_ff;
    assign trap_overflow             = ovf_ff;
    assign trap_underflow            = udf_ff;
endmodule // stack_limit_and_ram_guard

// File: tb_top.sv
// self-checking testbench for the stack limit and ram guard block
`timescale 1ns/1ps
module tb_top;
    localparam stack_guard_pkg::sp_op_type op_push = stack_guard_pkg::SP_OP_PUSH;
    localparam stack_guard_pkg::sp_op_type op_pop = stack_guard_pkg::SP_OP_POP;
    logic clk_sys = 1'h0, srst = 1'h1, sp_call_push = 1'h1, sp_exc_push = 1'h0, sp_wr = 1'h0, limit_wr = 1'h0;
    logic data_acc_valid = 1'h0, boot_ram_prot_en = 1'h0, code_in_boot_flash = 1'h0;
    logic secure_ram_prot_en = 1'h0, code_in_secure_flash = 1'h0;
    stack_guard_pkg::sp_op_type sp_op = stack_guard_pkg::SP_OP_NONE;
    logic [22:0] pc_value = 23'h5A1234;
    logic [7:0] status_low_byte = 8'hC3;
    logic [15:0] ea_addr = 16'h0806, sp_wr_data = 16'h0000, limit_wr_data = 16'h0000, data_acc_addr = 16'h0000;
    logic [15:0] boot_ram_start = 16'h1000, boot_ram_end = 16'h10FF, secure_ram_start = 16'h1100;
    logic [15:0] secure_ram_end = 16'h11FF, rd_lo, rd_hi, stack_pointer_working_reg, stack_upper_bound_reg;
    logic [15:0] stack_mem_addr, stack_push_data_lo, stack_push_data_hi;
    logic stack_mem_wr, stack_mem_rd, trap_overflow, trap_underflow, boot_ram_violation, secure_ram_violation;
    int err_count = 0;
    int n_tests = 0;
    always #12.5 clk_sys = ~clk_sys;
    stack_limit_and_ram_guard stack_limit_and_ram_guard_inst (.*);
    core_stack_mem core_stack_mem_inst (.*);
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask
    task automatic op(stack_guard_pkg::sp_op_type o);
        @(posedge clk_sys);
        #1 sp_op = o;
        @(posedge clk_sys);
        #1 sp_op = stack_guard_pkg::SP_OP_NONE;
    endtask
    // always leaves an idle cycle, so no pointer read follows a limit write at once
    task automatic wr_reg(logic lim, logic [15:0] v);
        @(posedge clk_sys);
        #1 {limit_wr, sp_wr, limit_wr_data, sp_wr_data} = {lim, !lim, v, v};
        @(posedge clk_sys);
        #1 {limit_wr, sp_wr} = 2'h0;
    endtask
    task automatic t_push;
        wr_reg(1'h1, 16'h0805);
        chk("limit", stack_upper_bound_reg, 16'h0804);
        op(op_push);
        chk("push addr", stack_mem_addr, 16'h0800);
        chk("call hi", stack_push_data_hi, 16'h005A);
        sp_exc_push = 1'h1;
        op(op_push);
        chk("exc hi", stack_push_data_hi, 16'hC35A);
        op(op_push);
        chk("push at limit", {15'h0000, stack_mem_wr}, 16'h0001);
        op(op_push);
        chk("overflow", {15'h0000, trap_overflow}, 16'h0001);
        chk("sp held", stack_pointer_working_reg, 16'h0806);
        $display("test push done");
    endtask
    task automatic t_pop;
        op(op_pop);
        chk("pop addr", stack_mem_addr, 16'h0804);
        chk("pop rd", {15'h0000, stack_mem_rd}, 16'h0001);
        chk("ovf pulse", {15'h0000, trap_overflow}, 16'h0000);
        chk("read lo", rd_lo, 16'h1234);
        op(op_pop);
        chk("read hi", rd_hi, 16'hC35A);
        op(op_pop);
        op(op_pop);
        chk("underflow", {15'h0000, trap_underflow}, 16'h0001);
        chk("sp floor", stack_pointer_working_reg, 16'h0800);
        $display("test pop done");
    endtask
    task automatic t_ea;
        wr_reg(1'h0, 16'h0803);
        chk("sp load", stack_pointer_working_reg, 16'h0802);
        op(stack_guard_pkg::SP_OP_EA);
        chk("ea over", {15'h0000, trap_overflow}, 16'h0001);
        $display("test ea done");
    endtask
    // segment ends are inclusive, so probe the shared boundary
    task automatic t_guard;
        {data_acc_valid, boot_ram_prot_en, secure_ram_prot_en} = 3'h7;
        for (int i = 0; i < 4; i++) begin
            data_acc_addr = i[1] ? 16'h1100 : 16'h10FF;
            {code_in_boot_flash, code_in_secure_flash} = {2{i[0]}};
            #5;
            chk("boot", {15'h0000, boot_ram_violation}, {15'h0000, !i[1] && !i[0]});
            chk("secure", {15'h0000, secure_ram_violation}, {15'h0000, i[1] && !i[0]});
        end
        $display("test guard done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        #1 srst = 1'h0;
        chk("sp reset", stack_pointer_working_reg, 16'h0800);
        t_push();
        t_pop();
        t_ea();
        t_guard();
        print_verdict();
    end
    initial begin
        repeat (400) @(posedge clk_sys);
        err_count++;
        print_verdict();
    end
endmodule // tb_top
